//--- design/rsq_reset_init.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Host uses primary clock, agent PCI sync
// - Straps valid 4 periods before negation
// - Release strap pins; redrive 1 period later
// - Capture four-bit source and divide strap
// - Host sync period from divide strap
// - Wait 100 us for PLL lock
module rsq_reset_init #(
  parameter int unsigned PLL_LOCK_CYCLES = rsq_pkg::PLL_LOCK_CYCLES
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                nrst,
  // Mode strap and input clocks, sampled
  input  wire logic                pci_host_mode,
  input  wire logic                primary_clock_input,
  input  wire logic                pci_sync_clock_input,
  // Reset pins
  input  wire logic                power_on_reset_line_n,
  input  wire logic                hard_reset_line_in_n,
  output logic                     hard_reset_line_out,
  output logic                     hard_reset_line_oe_n,
  // Configuration strap pins
  input  wire rsq_pkg::rsq_straps_t cfg_pins_in,
  input  wire rsq_pkg::rsq_straps_t cfg_drive_value,
  output rsq_pkg::rsq_straps_t     cfg_pins_out,
  output logic                     cfg_pins_oe_n,
  // Status towards the rest of the chip
  output rsq_pkg::rsq_straps_t     captured_straps,
  output logic                     primary_clock_select,
  output logic                     pll_locked,
  output logic                     chip_out_of_reset
);

  // Synchronised pin levels
  rsq_pkg::rsq_pins_t pins_s;
  // Previous levels for edge detection
  logic               prim_prev;
  logic               sync_prev;
  logic               por_prev;
  // External hard reset seen last cycle, marks the end of a short pulse
  logic               hrst_prev;
  // Host-mode divider phase
  logic               div_phase;
  // Shared period and cycle counter
  logic [15:0]        cnt;
  logic [15:0]        next_cnt;
  // Sequencer state
  rsq_pkg::rsq_state_t state;
  rsq_pkg::rsq_state_t next_state;

  // Both reset lines and the straps go through the synchroniser
  rsq_sync u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .pins_in  ({pci_host_mode, power_on_reset_line_n, hard_reset_line_in_n,
                primary_clock_input, pci_sync_clock_input, cfg_pins_in}),
    .pins_out (pins_s)
  );

  // Rising edges of the sampled clocks
  wire prim_edge = pins_s.primary_clock_input & ~prim_prev;
  wire sync_edge = pins_s.pci_sync_clock_input & ~sync_prev;
  // Power-on reset negation seen on the synchronised level
  wire por_rise  = pins_s.power_on_reset_line_n & ~por_prev;
  wire por_act   = ~pins_s.power_on_reset_line_n;
  // External hard reset, ignoring our own drive of the line
  wire hrst_ext  = ~pins_s.hard_reset_line_n & hard_reset_line_oe_n;
  // Host mode divides the primary clock by one or two
  wire host_tick = prim_edge & (~captured_straps.input_clock_divide_strap | div_phase);
  // One period of the PCI sync clock, host or agent
  wire sync_tick = primary_clock_select ? host_tick : sync_edge;
  // Reference period for power-on reset, chosen by mode
  wire ref_tick  = pins_s.host_mode ? prim_edge : sync_edge;
  // Last counter value of an input pulse that is long enough
  localparam logic [15:0] HRST_IN_LAST = rsq_pkg::HRST_IN_PERIODS - 16'h0001;

  // Count reached helpers
  wire pll_done  = (cnt >= 16'(PLL_LOCK_CYCLES - 1));
  // First tick may land right after the start, so one extra tick makes
  // the hard reset drive and redrive spans a full number of periods
  wire hout_done = sync_tick & (cnt >= rsq_pkg::HRST_OUT_PERIODS);
  wire hin_done  = sync_tick & (cnt >= HRST_IN_LAST);
  wire cfg_done  = sync_tick & (cnt >= rsq_pkg::CFG_ON_PERIODS);

  // Edge history and divider phase
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prim_prev <= 1'b0;
      sync_prev <= 1'b0;
      por_prev  <= 1'b0;
      hrst_prev <= 1'b0;
      div_phase <= 1'b0;
    end else begin
      prim_prev <= pins_s.primary_clock_input;
      sync_prev <= pins_s.pci_sync_clock_input;
      por_prev  <= pins_s.power_on_reset_line_n;
      hrst_prev <= hrst_ext;
      // Phase restarts with every power-on reset
      div_phase <= por_act ? 1'b0 : (prim_edge ? ~div_phase : div_phase);
    end
  end

  // Next state and counter
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      rsq_pkg::RSQ_POR: begin
        // Count reference periods for status only; negation is honoured
        if (por_rise) begin
          next_state = rsq_pkg::RSQ_PLL_WAIT;
          next_cnt   = '0;
        end else if (ref_tick && cnt != 16'hFFFF) begin
          next_cnt = cnt + 16'h0001;
        end
      end
      rsq_pkg::RSQ_PLL_WAIT: begin
        // Core clock only counts; PLL output not trusted yet
        if (pll_done) begin
          next_state = rsq_pkg::RSQ_HRST_OUT;
          next_cnt   = '0;
        end else begin
          next_cnt = cnt + 16'h0001;
        end
      end
      rsq_pkg::RSQ_HRST_OUT: begin
        // Hold our hard reset drive for the full count
        if (hout_done) begin
          next_state = rsq_pkg::RSQ_CFG_WAIT;
          next_cnt   = '0;
        end else if (sync_tick) begin
          next_cnt = cnt + 16'h0001;
        end
      end
      rsq_pkg::RSQ_CFG_WAIT: begin
        // Count only once the line is really high again
        if (~pins_s.hard_reset_line_n) begin
          next_cnt = '0;
        end else if (cfg_done) begin
          next_state = rsq_pkg::RSQ_RUN;
          next_cnt   = '0;
        end else if (sync_tick) begin
          next_cnt = cnt + 16'h0001;
        end
      end
      rsq_pkg::RSQ_RUN: begin
        if (hrst_ext) begin
          // Low long enough: join the reset with our own drive
          if (hin_done) begin
            next_state = rsq_pkg::RSQ_HRST_OUT;
            next_cnt   = '0;
          end else if (sync_tick) begin
            next_cnt = cnt + 16'h0001;
          end
        end else if (hrst_prev) begin
          // Short pulse over; straps still wait a period before redrive
          next_state = rsq_pkg::RSQ_CFG_WAIT;
          next_cnt   = '0;
        end else begin
          next_cnt = '0;
        end
      end
      default: begin
        next_state = rsq_pkg::RSQ_POR;
        next_cnt   = '0;
      end
    endcase
    // Power-on reset overrides any flow in progress
    if (por_act && state != rsq_pkg::RSQ_POR) begin
      next_state = rsq_pkg::RSQ_POR;
      next_cnt   = '0;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= rsq_pkg::RSQ_POR;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Strap capture and clock selection at power-on reset negation
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      captured_straps      <= {rsq_pkg::RST_SRC_RESET, rsq_pkg::CLK_DIV_RESET};
      primary_clock_select <= 1'b1;
    end else if (state == rsq_pkg::RSQ_POR && por_rise) begin
      // Straps pass the same synchroniser, so they line up with negation
      captured_straps      <= pins_s.straps;
      primary_clock_select <= pins_s.host_mode;
    end
  end

  // Pin drivers and status flags
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hard_reset_line_out  <= 1'b0;
      hard_reset_line_oe_n <= 1'b1;
      cfg_pins_out         <= '0;
      cfg_pins_oe_n        <= 1'b1;
      pll_locked           <= 1'b0;
      chip_out_of_reset    <= 1'b0;
    end else begin
      // Open-drain: line is only ever pulled low
      hard_reset_line_out  <= 1'b0;
      hard_reset_line_oe_n <= (next_state != rsq_pkg::RSQ_HRST_OUT);
      cfg_pins_out         <= cfg_drive_value;
      // Any sign of hard reset drops the strap drive at once
      cfg_pins_oe_n        <= (next_state != rsq_pkg::RSQ_RUN) | hrst_ext;
      pll_locked           <= (next_state == rsq_pkg::RSQ_HRST_OUT) |
                              (next_state == rsq_pkg::RSQ_CFG_WAIT) |
                              (next_state == rsq_pkg::RSQ_RUN);
      chip_out_of_reset    <= (next_state == rsq_pkg::RSQ_RUN);
    end
  end

endmodule : rsq_reset_init
`default_nettype wire

//--- design/rsq_sync.sv
`timescale 1ns/10ps
`default_nettype none
module rsq_sync (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  // Asynchronous pins in, synchronised pins out
  input  wire rsq_pkg::rsq_pins_t    pins_in,
  output var  rsq_pkg::rsq_pins_t    pins_out
);

  // First stage, read only by the second stage
  rsq_pkg::rsq_pins_t meta;

  // Two flops; resets read as asserted so nothing leaves reset early
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta     <= '0;
      pins_out <= '0;
    end else begin
      meta     <= pins_in;
      pins_out <= meta;
    end
  end

endmodule : rsq_sync
`default_nettype wire

//--- inc/rsq_pkg.sv
`default_nettype none
package rsq_pkg;

  // Core clock
  localparam int unsigned CLK_PERIOD_NS     = 20;
  // Lock time of every internal PLL
  localparam int unsigned PLL_LOCK_TIME_US  = 100;
  localparam int unsigned PLL_LOCK_CYCLES   =
    (PLL_LOCK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Counts in reference or sync clock periods
  localparam logic [15:0] POR_MIN_PERIODS   = 16'h0020;
  localparam logic [15:0] HRST_IN_PERIODS   = 16'h0020;
  localparam logic [15:0] HRST_OUT_PERIODS  = 16'h0200;
  localparam logic [15:0] CFG_ON_PERIODS    = 16'h0001;
  // Synchroniser depth and width
  localparam int unsigned SYNC_STAGES       = 2;
  localparam int unsigned SYNC_WIDTH        = 10;
  // Strap reset values
  localparam logic [3:0]  RST_SRC_RESET     = 4'h0;
  localparam logic        CLK_DIV_RESET     = 1'b0;

  // Captured power-on configuration
  typedef struct packed {
    logic [3:0] reset_source;
    logic       input_clock_divide_strap;
  } rsq_straps_t;

  // Raw pin levels that pass the synchroniser
  typedef struct packed {
    logic        host_mode;
    logic        power_on_reset_line_n;
    logic        hard_reset_line_n;
    logic        primary_clock_input;
    logic        pci_sync_clock_input;
    rsq_straps_t straps;
  } rsq_pins_t;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    RSQ_POR      = 5'b00001,
    RSQ_PLL_WAIT = 5'b00010,
    RSQ_HRST_OUT = 5'b00100,
    RSQ_CFG_WAIT = 5'b01000,
    RSQ_RUN      = 5'b10000
  } rsq_state_t;

endpackage : rsq_pkg
`default_nettype wire

//--- verification/rsq_board_model.sv
`timescale 1ns/10ps
`default_nettype none
module rsq_board_model (
  // Board reference
  input wire logic core_clk,
  // Parties on the hard reset wire
  input wire logic ext_hrst_n,
  input wire logic dev_oe_n,
  // Seen by the device
  output logic     primary_clk,
  output logic     sync_clk,
  output logic     hrst_wire_n
);
  logic [3:0] phase = 4'h0; // Twelve-cycle phase of both clocks
  // Clocks run free, stable before power-on release
  always @(posedge core_clk) phase <= (phase == 4'hB) ? 4'h0 : phase + 4'h1;
  // Periods of four and twelve cycles, both inside the allowed range
  assign primary_clk = phase[1];
  assign sync_clk    = phase > 4'h5;
  // Pull-up wire, low when either party pulls
  assign hrst_wire_n = ext_hrst_n & dev_oe_n;
endmodule : rsq_board_model
`default_nettype wire

//--- verification/rsq_reset_init_properties.sv
`timescale 1ns/10ps
`default_nettype none
module rsq_reset_init_properties #(
  parameter int unsigned PLL_LOCK_CYCLES = 20
) (
  // Clock and reset
  input wire logic                 core_clk,
  input wire logic                 nrst,
  // Pins
  input wire logic                 pci_host_mode,
  input wire logic                 primary_clock_input,
  input wire logic                 pci_sync_clock_input,
  input wire logic                 power_on_reset_line_n,
  input wire logic                 hard_reset_line_in_n,
  input wire rsq_pkg::rsq_straps_t cfg_pins_in,
  // Outputs
  input wire logic                 hard_reset_line_out,
  input wire logic                 hard_reset_line_oe_n,
  input wire logic                 cfg_pins_oe_n,
  input wire rsq_pkg::rsq_straps_t captured_straps,
  input wire logic                 primary_clock_select,
  input wire logic                 pll_locked,
  input wire logic                 chip_out_of_reset
);
  logic [15:0]          lock_cnt;   // Cycles since power-on release
  logic [11:0]          tick_cnt;   // Raw reference rises while we pull
  logic [1:0]           clk_q;      // Last clock levels
  rsq_pkg::rsq_straps_t por_straps; // Straps while power-on held
  logic [1:0]           hi_ticks;   // Reference rises since line went high
  wire logic tick = pci_host_mode ? (primary_clock_input & ~clk_q[1])
                                  : (pci_sync_clock_input & ~clk_q[0]);
  // Divide strap doubles primary rises; full 512 periods required
  wire logic [11:0] need = (pci_host_mode && captured_straps.input_clock_divide_strap)
                           ? 12'h400 : 12'h200;
  // Rises needed before redrive: two sync ticks span one full period
  wire logic [1:0]  need_on = (pci_host_mode && captured_straps.input_clock_divide_strap)
                              ? 2'h3 : 2'h2;
  // Helper counters
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lock_cnt   <= 16'h0000;
      tick_cnt   <= 12'h000;
      clk_q      <= 2'h0;
      por_straps <= '0;
      hi_ticks   <= 2'h0;
    end else begin
      clk_q    <= {primary_clock_input, pci_sync_clock_input};
      lock_cnt <= !power_on_reset_line_n ? 16'h0000 : lock_cnt + {15'h0000, !pll_locked};
      tick_cnt <= hard_reset_line_oe_n ? 12'h000 : tick_cnt + {11'h000, tick};
      hi_ticks <= !hard_reset_line_in_n ? 2'h0 : hi_ticks + {1'b0, tick & (hi_ticks != 2'h3)};
      if (!power_on_reset_line_n) por_straps <= cfg_pins_in;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Our drive ends outside a power-on restart
  sequence hrst_end;
    $rose(hard_reset_line_oe_n) && power_on_reset_line_n;
  endsequence
  sequence lock_seen;
    $rose(pll_locked);
  endsequence
  od_data_low_a: assert property (hard_reset_line_out == 1'b0)
    else $error("hard reset data not low");
  hrst_len_a: assert property (hrst_end |-> tick_cnt >= need)
    else $error("hard reset drive too short");
  pll_wait_a: assert property (lock_seen |->
    lock_cnt inside {[PLL_LOCK_CYCLES:PLL_LOCK_CYCLES + 6]})
    else $error("pll wait length wrong");
  clk_select_a: assert property (lock_seen |-> primary_clock_select == pci_host_mode)
    else $error("clock select wrong");
  strap_cap_a: assert property (lock_seen |-> captured_straps == por_straps)
    else $error("captured straps wrong");
  cfg_release_a: assert property (!hard_reset_line_in_n [*4] |-> cfg_pins_oe_n)
    else $error("strap pins still driven");
  cfg_redrive_a: assert property ($fell(cfg_pins_oe_n) |->
    $past(hard_reset_line_in_n, 3) && hi_ticks >= need_on)
    else $error("strap pins driven too early");
  drive_holdoff_a: assert property (!hard_reset_line_oe_n |-> cfg_pins_oe_n)
    else $error("straps driven during hard reset");
  por_restart_a: assert property ($fell(power_on_reset_line_n) |->
    ##[1:4] (!pll_locked && cfg_pins_oe_n && hard_reset_line_oe_n))
    else $error("power-on restart missing");
  run_order_a: assert property ($rose(chip_out_of_reset) |->
    !cfg_pins_oe_n && hard_reset_line_oe_n)
    else $error("run entered out of order");
endmodule : rsq_reset_init_properties
bind rsq_reset_init rsq_reset_init_properties #(.PLL_LOCK_CYCLES(PLL_LOCK_CYCLES)) u_props (
  .core_clk(core_clk), .nrst(nrst), .pci_host_mode(pci_host_mode),
  .primary_clock_input(primary_clock_input), .pci_sync_clock_input(pci_sync_clock_input),
  .power_on_reset_line_n(power_on_reset_line_n), .hard_reset_line_in_n(hard_reset_line_in_n),
  .cfg_pins_in(cfg_pins_in), .hard_reset_line_out(hard_reset_line_out),
  .hard_reset_line_oe_n(hard_reset_line_oe_n), .cfg_pins_oe_n(cfg_pins_oe_n),
  .captured_straps(captured_straps), .primary_clock_select(primary_clock_select),
  .pll_locked(pll_locked), .chip_out_of_reset(chip_out_of_reset));
`default_nettype wire

//--- verification/tb_reset_init_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module tb_reset_init_sequencer;
  localparam int LOCK = 20; // Short PLL wait
  logic                 core_clk = 1'b0;
  logic                 nrst = 1'b0;
  logic                 host = 1'b1;
  logic                 por_n = 1'b0;
  logic                 ext_n = 1'b1;
  rsq_pkg::rsq_straps_t straps = '0;
  logic                 prim, sync, line_n, od_out, oe_n, cfg_oe_n, sel, locked, run;
  rsq_pkg::rsq_straps_t cfg_out, cap, cfg_wire;
  int                   fail_count = 0;
  int                   compares = 0;
  // Strap pins show the board value while the device is off them
  assign cfg_wire = cfg_oe_n ? straps : cfg_out;
  always #10 core_clk = ~core_clk;
  rsq_board_model board (.core_clk(core_clk), .ext_hrst_n(ext_n), .dev_oe_n(oe_n),
    .primary_clk(prim), .sync_clk(sync), .hrst_wire_n(line_n));
  rsq_reset_init #(.PLL_LOCK_CYCLES(LOCK)) dut (.core_clk(core_clk), .nrst(nrst),
    .pci_host_mode(host), .primary_clock_input(prim), .pci_sync_clock_input(sync),
    .power_on_reset_line_n(por_n), .hard_reset_line_in_n(line_n),
    .hard_reset_line_out(od_out), .hard_reset_line_oe_n(oe_n), .cfg_pins_in(cfg_wire),
    .cfg_drive_value(5'h15), .cfg_pins_out(cfg_out), .cfg_pins_oe_n(cfg_oe_n),
    .captured_straps(cap), .primary_clock_select(sel), .pll_locked(locked),
    .chip_out_of_reset(run));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // Watched output: 0 hard reset drive, 1 run flag, else strap drive
  function automatic logic watched(input int which);
    case (which)
      0: return oe_n;
      1: return run;
      default: return cfg_oe_n;
    endcase
  endfunction : watched
  // Bounded wait for a level, cycles spent in n
  task automatic wait_lvl(input int which, input logic v, output int n);
    n = 0;
    while (watched(which) !== v) begin
      @(posedge core_clk);
      #1;
      n++;
      if (n > 9000) begin
        fail_count++;
        wrap_up();
      end
    end
  endtask : wait_lvl
  // Power-on flow in one mode; one tick is per cycles
  task automatic flow(input logic h, input logic [4:0] s);
    int n;
    int per;
    per = h ? (s[0] ? 8 : 4) : 12;
    @(posedge core_clk);
    por_n <= 1'b0;
    host <= h;
    straps <= s;
    repeat (400) @(posedge core_clk);
    por_n <= 1'b1;
    #1;
    wait_lvl(0, 1'b0, n);
    check("pll wait", n >= LOCK, 1'b1);
    wait_lvl(0, 1'b1, n);
    check("hard reset length", n >= 512 * per, 1'b1);
    wait_lvl(1, 1'b1, n);
    check("captured straps", cap, s);
    check("clock select", sel, h);
    check("strap drive", {cfg_oe_n, cfg_out}, 6'h15);
    check("pll locked", locked, 1'b1);
    $display("flow host %0d straps %h done", h, s);
  endtask : flow
  // Short then long outside hard reset while running
  task automatic ext_pulse;
    int n;
    @(posedge core_clk);
    ext_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    check("strap release", cfg_oe_n, 1'b1);
    check("short pulse ignored", oe_n, 1'b1);
    @(posedge core_clk);
    ext_n <= 1'b1;
    wait_lvl(2, 1'b0, n);
    check("redrive holdoff", n >= 12, 1'b1);
    @(posedge core_clk);
    ext_n <= 1'b0;
    repeat (420) @(posedge core_clk);
    #1;
    check("device joins reset", oe_n, 1'b0);
    @(posedge core_clk);
    ext_n <= 1'b1;
    wait_lvl(1, 1'b1, n);
    check("strap redrive", cfg_oe_n, 1'b0);
    $display("outside hard reset done");
  endtask : ext_pulse
  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    flow(1'b1, 5'h14);
    flow(1'b1, 5'h0B);
    flow(1'b0, 5'h06);
    ext_pulse();
    wrap_up();
  end
endmodule : tb_reset_init_sequencer
`default_nettype wire
